// File: design/htf_pkg.sv
package htf_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_BRIDGE_SLEW_TRIM = 8'h62;
    localparam logic [7:0] ADDR_LOOP_MISC_CONFIG = 8'h6E;
    localparam logic [7:0] ADDR_ACTUATOR_FAULT_EVENTS = 8'h81;
    localparam logic [7:0] ADDR_FAULT_STATUS_TWO = 8'h82;
    localparam logic [7:0] ADDR_FAULT_MASK_TWO = 8'h83;
    localparam logic [7:0] ADDR_SNIPPET_FIRST = 8'h84;
    localparam logic [7:0] ADDR_SNIPPET_LAST = 8'hE7;
    localparam int SNIPPET_BYTES = 100;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_LOW_SIDE_SLEW = 2;
    localparam int POS_HIGH_SIDE_SLEW = 0;
    localparam int POS_DELAY_BYPASS = 2;
    localparam int POS_FREQ_HOLD = 1;
    localparam int POS_OFFSET_ENABLE = 0;
    localparam int POS_CLIP_EVENT = 2;
    localparam int POS_CLIP_STATE = 7;
    localparam int POS_CLIP_MASK = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_SLEW = 2'h3;
    localparam logic RST_CFG_BIT = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [7:0] RST_SNIPPET = 8'h00;

    // ------------------------------------------------------------
    // analogue figures behind the codes
    // ------------------------------------------------------------
    localparam int SLEW_STEP_MV_PER_NS = 25;
    localparam int CONVERSION_OFFSET_MV = 50;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } htf_bus_req_t;

    typedef struct packed {
        logic [1:0] lowSideSlewSelect;
        logic [1:0] highSideSlewSelect;
        logic delayBypass;
        logic freqHoldOnReversal;
        logic conversionOffsetEnable;
    } htf_cfg_t;

endpackage

// File: design/htf_snippet_mem.sv
`timescale 1ns/10ps
module htf_snippet_mem
    import htf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [6:0] index,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] memQ [SNIPPET_BYTES];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // R11: bytes reset to zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < SNIPPET_BYTES; i++)
                memQ[i] <= RST_SNIPPET;
        end
        else if (wrEn)
            memQ[index] <= wdata;
    end

    // R12: byte order by index
    assign rdata = memQ[index];

endmodule

// File: design/htf_regs.sv
`timescale 1ns/10ps
// What this block does
// R1: low-side slew code in bits 3:2, steps 25..100 mV/ns, resets to 3.
// R2: high-side slew code in bits 1:0, same steps, resets to 3.
// R3: loop config bit 2 bypasses delay comparator; resets to no bypass.
// R4: hold bit set pauses frequency update on every drive polarity reversal.
// R5: offset bit set adds 50 mV to conversion factor calculation.
// R6: clip event flag bit 2 sets on saturated converter result; resets 0.
// R7: clip event flag clears only when software writes one to it.
// R8: status two bit 7 shows present clip fault state; resets 0.
// R9: mask two bit 7 blocks clip fault from interrupt output; resets 0.
// R10: snippet bytes at consecutive addresses 0x84 through 0xE7.
// R11: each snippet byte is eight bits, read-write, resets to zero.
// R12: snippet byte 0 lowest address, byte 99 highest.
// R13: reads never change event, status or mask contents.
module htf_regs
    import htf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic converterClipIn,
    input wire logic polarityReversal,
    input wire logic freqUpdateReq,
    output logic freqUpdateEn,
    output htf_cfg_t cfg,
    output logic [7:0] conversionOffsetMv,
    output logic [6:0] lowSideSlewMvPerNs,
    output logic [6:0] highSideSlewMvPerNs,
    output logic clipIrq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] slew_rate(input logic [1:0] code);
        slew_rate = 7'(SLEW_STEP_MV_PER_NS * (int'(code) + 1));
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    htf_bus_req_t req;
    htf_cfg_t cfgQ;
    logic clipSyncA_q;
    logic clipSyncB_q;
    logic clipEventQ;
    logic clipMaskQ;
    logic [7:0] rdataQ;
    logic [7:0] rdataD;
    logic [7:0] snipRdata;
    logic [6:0] snipIndex;
    logic snipHit;
    logic snipWr;
    logic clipClear;
    logic wrSlew;
    logic wrLoop;
    logic wrMask;

    assign req = '{write: regWrite, read: regRead, addr: regAddr,
                   wdata: regWdata};

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // R10: snippet window decode
    assign snipHit = (req.addr >= ADDR_SNIPPET_FIRST) &&
                     (req.addr <= ADDR_SNIPPET_LAST);
    // R12: index from offset
    assign snipIndex = 7'(req.addr - ADDR_SNIPPET_FIRST);
    assign snipWr = req.write && snipHit;
    assign wrSlew = req.write && hit(req.addr, ADDR_BRIDGE_SLEW_TRIM);
    assign wrLoop = req.write && hit(req.addr, ADDR_LOOP_MISC_CONFIG);
    assign wrMask = req.write && hit(req.addr, ADDR_FAULT_MASK_TWO);
    // R7: write one clears event
    assign clipClear = req.write &&
                       hit(req.addr, ADDR_ACTUATOR_FAULT_EVENTS) &&
                       req.wdata[POS_CLIP_EVENT];

    // ------------------------------------------------------------
    // clip input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clipSyncA_q <= 1'b0;
            clipSyncB_q <= 1'b0;
        end
        else
        begin
            clipSyncA_q <= converterClipIn;
            clipSyncB_q <= clipSyncA_q;
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // R1: low slew reset code
            cfgQ.lowSideSlewSelect <= RST_SLEW;
            // R2: high slew reset code
            cfgQ.highSideSlewSelect <= RST_SLEW;
            // R3: bypass off at reset
            cfgQ.delayBypass <= RST_CFG_BIT;
            cfgQ.freqHoldOnReversal <= RST_CFG_BIT;
            cfgQ.conversionOffsetEnable <= RST_CFG_BIT;
            // R9: mask clear at reset
            clipMaskQ <= RST_FLAG;
        end
        else
        begin
            if (wrSlew)
            begin
                // R1: low slew write
                cfgQ.lowSideSlewSelect <=
                    req.wdata[POS_LOW_SIDE_SLEW +: 2];
                // R2: high slew write
                cfgQ.highSideSlewSelect <=
                    req.wdata[POS_HIGH_SIDE_SLEW +: 2];
            end
            if (wrLoop)
            begin
                // R3: bypass write
                cfgQ.delayBypass <= req.wdata[POS_DELAY_BYPASS];
                cfgQ.freqHoldOnReversal <= req.wdata[POS_FREQ_HOLD];
                cfgQ.conversionOffsetEnable <= req.wdata[POS_OFFSET_ENABLE];
            end
            // R9: mask write
            if (wrMask)
                clipMaskQ <= req.wdata[POS_CLIP_MASK];
        end
    end

    // ------------------------------------------------------------
    // clip event flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            clipEventQ <= RST_FLAG;
        // R6: set wins over clear
        else if (clipSyncB_q)
            clipEventQ <= 1'b1;
        else if (clipClear)
            clipEventQ <= 1'b0;
    end

    // ------------------------------------------------------------
    // snippet memory
    // ------------------------------------------------------------
    htf_snippet_mem u_snip
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(snipWr),
        .index(snipIndex),
        .wdata(req.wdata),
        .rdata(snipRdata)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // R13: reads have no side effect
    always_comb
    begin
        rdataD = 8'h00;
        if (snipHit)
            rdataD = snipRdata;
        else
        begin
            case (req.addr)
                ADDR_BRIDGE_SLEW_TRIM:
                begin
                    rdataD[POS_LOW_SIDE_SLEW +: 2] = cfgQ.lowSideSlewSelect;
                    rdataD[POS_HIGH_SIDE_SLEW +: 2] =
                        cfgQ.highSideSlewSelect;
                end
                ADDR_LOOP_MISC_CONFIG:
                begin
                    rdataD[POS_DELAY_BYPASS] = cfgQ.delayBypass;
                    rdataD[POS_FREQ_HOLD] = cfgQ.freqHoldOnReversal;
                    rdataD[POS_OFFSET_ENABLE] = cfgQ.conversionOffsetEnable;
                end
                ADDR_ACTUATOR_FAULT_EVENTS:
                    rdataD[POS_CLIP_EVENT] = clipEventQ;
                // R8: present clip state
                ADDR_FAULT_STATUS_TWO:
                    rdataD[POS_CLIP_STATE] = clipSyncB_q;
                ADDR_FAULT_MASK_TWO:
                    rdataD[POS_CLIP_MASK] = clipMaskQ;
                default:
                    rdataD = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdataQ <= 8'h00;
        else if (req.read)
            rdataQ <= rdataD;
        else
            rdataQ <= 8'h00;
    end

    assign regRdata = rdataQ;

    // ------------------------------------------------------------
    // outputs to the loop
    // ------------------------------------------------------------
    assign cfg = cfgQ;
    // R1: low slew figure
    assign lowSideSlewMvPerNs = slew_rate(cfgQ.lowSideSlewSelect);
    // R2: high slew figure
    assign highSideSlewMvPerNs = slew_rate(cfgQ.highSideSlewSelect);
    // R4: hold update on reversal
    assign freqUpdateEn = freqUpdateReq &&
                          !(cfgQ.freqHoldOnReversal && polarityReversal);
    // R5: offset figure
    assign conversionOffsetMv = cfgQ.conversionOffsetEnable ?
                                8'(CONVERSION_OFFSET_MV) : 8'h00;
    // R9: mask gates interrupt
    assign clipIrq = clipEventQ && !clipMaskQ;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_clip_sets;
        @(posedge clk) disable iff (sys_rst)
        clipSyncB_q |=> clipEventQ;
    endproperty
    a_clip_sets: assert property (p_clip_sets) // R6
        else $error("clip event not set");

    property p_clip_holds;
        @(posedge clk) disable iff (sys_rst)
        clipEventQ && !clipClear |=> clipEventQ;
    endproperty
    a_clip_holds: assert property (p_clip_holds) // R7
        else $error("clip event lost without clear");

    property p_clip_clears;
        @(posedge clk) disable iff (sys_rst)
        clipClear && !clipSyncB_q |=> !clipEventQ;
    endproperty
    a_clip_clears: assert property (p_clip_clears) // R7
        else $error("clip event not cleared");

    property p_mask;
        @(posedge clk) disable iff (sys_rst)
        clipMaskQ |-> !clipIrq;
    endproperty
    a_mask: assert property (p_mask) // R9
        else $error("masked clip raised irq");

    property p_status_read;
        @(posedge clk) disable iff (sys_rst)
        req.read && hit(req.addr, ADDR_FAULT_STATUS_TWO)
        |=> regRdata[POS_CLIP_STATE] == $past(clipSyncB_q);
    endproperty
    a_status_read: assert property (p_status_read) // R8
        else $error("status bit wrong");

    property p_slew_write;
        @(posedge clk) disable iff (sys_rst)
        wrSlew |=> cfgQ.lowSideSlewSelect == $past(req.wdata[3:2]) &&
                   cfgQ.highSideSlewSelect == $past(req.wdata[1:0]);
    endproperty
    a_slew_write: assert property (p_slew_write) // R1
        else $error("slew write lost");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        cfgQ.freqHoldOnReversal && polarityReversal |-> !freqUpdateEn;
    endproperty
    a_hold: assert property (p_hold) // R4
        else $error("update not held");

    property p_offset;
        @(posedge clk) disable iff (sys_rst)
        cfgQ.conversionOffsetEnable |-> conversionOffsetMv == 8'h32;
    endproperty
    a_offset: assert property (p_offset) // R5
        else $error("offset wrong");

    property p_bypass;
        @(posedge clk) disable iff (sys_rst)
        wrLoop |=> cfgQ.delayBypass == $past(req.wdata[2]);
    endproperty
    a_bypass: assert property (p_bypass) // R3
        else $error("bypass write lost");

    property p_read_quiet;
        @(posedge clk) disable iff (sys_rst)
        req.read && !req.write && !clipSyncB_q |=> $stable(clipEventQ);
    endproperty
    a_read_quiet: assert property (p_read_quiet) // R13
        else $error("read changed event");

endmodule

// File: dv/htf_regs_tb_top.sv
`timescale 1ns/10ps
module htf_regs_tb_top
    import htf_pkg::*;
();
    logic clk;
    logic sys_rst;
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic converterClipIn;
    logic polarityReversal;
    logic freqUpdateReq;
    logic freqUpdateEn;
    htf_cfg_t cfg;
    logic [7:0] conversionOffsetMv;
    logic [6:0] lowSideSlewMvPerNs;
    logic [6:0] highSideSlewMvPerNs;
    logic clipIrq;
    int fail_count;
    int compares;
    int cycles;
    int regModel[256];
    int evt;
    int clip;
    int d;

    htf_regs u_htf_regs (
        .clk(clk),
        .sys_rst(sys_rst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .converterClipIn(converterClipIn),
        .polarityReversal(polarityReversal),
        .freqUpdateReq(freqUpdateReq),
        .freqUpdateEn(freqUpdateEn),
        .cfg(cfg),
        .conversionOffsetMv(conversionOffsetMv),
        .lowSideSlewMvPerNs(lowSideSlewMvPerNs),
        .highSideSlewMvPerNs(highSideSlewMvPerNs),
        .clipIrq(clipIrq)
    );

    // ------------------------------------------------------------
    // bench helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %0t want %h got %h", $time, e, g);
        end
    endtask

    task automatic mdl_wr(input int a, input int v);
        if (a == ADDR_BRIDGE_SLEW_TRIM)
            regModel[a] = v & 'h0F;
        else if (a == ADDR_LOOP_MISC_CONFIG)
            regModel[a] = v & 'h07;
        else if (a == ADDR_FAULT_MASK_TWO)
            regModel[a] = v & 'h80;
        else if (a == ADDR_ACTUATOR_FAULT_EVENTS && v[2] && clip == 0)
            evt = 0;
        else if (a >= ADDR_SNIPPET_FIRST && a <= ADDR_SNIPPET_LAST)
            regModel[a] = v & 'hFF;
    endtask

    function automatic logic [7:0] exp_rd(input int a);
        if (a == ADDR_ACTUATOR_FAULT_EVENTS)
            return 8'(evt << POS_CLIP_EVENT);
        if (a == ADDR_FAULT_STATUS_TWO)
            return 8'(clip << POS_CLIP_STATE);
        return 8'(regModel[a]);
    endfunction

    task automatic wr(input int a, input int v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= 8'(a);
        regWdata <= 8'(v);
        @(posedge clk);
        regWrite <= 1'b0;
        mdl_wr(a, v);
    endtask

    task automatic rd(input int a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= 8'(a);
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(exp_rd(a), regRdata);
    endtask

    task automatic chk_cfg();
        int lo;
        int hi;
        lo = regModel[ADDR_BRIDGE_SLEW_TRIM] >> POS_LOW_SIDE_SLEW & 3;
        hi = regModel[ADDR_BRIDGE_SLEW_TRIM] >> POS_HIGH_SIDE_SLEW & 3;
        d = regModel[ADDR_LOOP_MISC_CONFIG];
        chk(8'(lo), 8'(cfg.lowSideSlewSelect));
        chk(8'(SLEW_STEP_MV_PER_NS * (lo + 1)), 8'(lowSideSlewMvPerNs));
        chk(8'(hi), 8'(cfg.highSideSlewSelect));
        chk(8'(SLEW_STEP_MV_PER_NS * (hi + 1)), 8'(highSideSlewMvPerNs));
        chk(8'(d[POS_DELAY_BYPASS]), 8'(cfg.delayBypass));
        chk(8'(d[POS_FREQ_HOLD]), 8'(cfg.freqHoldOnReversal));
        chk(8'(d[0] ? CONVERSION_OFFSET_MV : 0), conversionOffsetMv);
    endtask

    task automatic clip_set(input int v);
        @(posedge clk);
        converterClipIn <= v[0];
        repeat (3) @(posedge clk);
        #1;
        clip = v;
        if (v != 0)
            evt = 1;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        converterClipIn = 1'b0;
        polarityReversal = 1'b0;
        freqUpdateReq = 1'b0;
        fail_count = 0;
        compares = 0;
        evt = 0;
        clip = 0;
        foreach (regModel[i])
            regModel[i] = 0;
        regModel[ADDR_BRIDGE_SLEW_TRIM] = {RST_SLEW, RST_SLEW};
        d = $urandom(32'h030B0A91);
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values
        for (int a = 'h60; a <= 'hE9; a++)
            rd(a);
        chk_cfg();
        // every slew code and config bit
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_BRIDGE_SLEW_TRIM, $urandom & 'hF0 | i);
            wr(ADDR_LOOP_MISC_CONFIG, $urandom & 'hF8 | i & 7);
            rd(ADDR_BRIDGE_SLEW_TRIM);
            rd(ADDR_LOOP_MISC_CONFIG);
            chk_cfg();
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk);
                polarityReversal <= 1'($urandom);
                freqUpdateReq <= 1'($urandom);
                #1;
                chk(8'(freqUpdateReq && !(d[POS_FREQ_HOLD]
                    && polarityReversal)), 8'(freqUpdateEn));
            end
        end
        // snippet bytes, unmapped and read-only places
        for (int a = 'h80; a <= 'hE8; a++)
            wr(a, $urandom);
        for (int a = 'h80; a <= 'hE8; a++)
            rd(a);
        @(posedge clk);
        #1;
        chk(8'h00, regRdata);
        // clip fault: sticky event, state, mask
        clip_set(1);
        chk(8'(regModel[ADDR_FAULT_MASK_TWO] == 0), 8'(clipIrq));
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        rd(ADDR_FAULT_STATUS_TWO);
        wr(ADDR_ACTUATOR_FAULT_EVENTS, 'hFF);
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        wr(ADDR_FAULT_MASK_TWO, 'hFF);
        rd(ADDR_FAULT_MASK_TWO);
        #1;
        chk(8'h00, 8'(clipIrq));
        wr(ADDR_FAULT_MASK_TWO, 'h00);
        clip_set(0);
        rd(ADDR_FAULT_STATUS_TWO);
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        chk(8'h01, 8'(clipIrq));
        wr(ADDR_ACTUATOR_FAULT_EVENTS, 'hFB);
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        wr(ADDR_ACTUATOR_FAULT_EVENTS, 'h04);
        rd(ADDR_ACTUATOR_FAULT_EVENTS);
        #1;
        chk(8'h00, 8'(clipIrq));
        print_verdict();
    end
endmodule
